/* include/tms_pkg.sv */
// Package for the timer with mode strap block
package tms_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_MASK    = 8'h08;
	localparam logic [7:0] OFF_COUNT   = 8'h0c;
	localparam logic [7:0] OFF_COMPARE = 8'h10;
	localparam logic [7:0] OFF_CAPTURE = 8'h14;
	localparam logic [7:0] OFF_STRAP   = 8'h18;
	localparam logic [7:0] OFF_PORTB   = 8'h1c;
	localparam logic [7:0] OFF_PORTC   = 8'h20;
	localparam logic [7:0] OFF_DDRB    = 8'h24;
	localparam logic [7:0] OFF_DDRC    = 8'h28;
	localparam logic [7:0] OFF_EXPB    = 8'h2c;
	localparam logic [7:0] OFF_EXPC    = 8'h30;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_PIN_EN    = 0;
	localparam int CTRL_CMP_LEVEL = 1;
	localparam int CTRL_CAP_EDGE  = 2;
	localparam int ST_CMP         = 0;
	localparam int ST_CAP         = 1;
	localparam int PB_CMP_BIT     = 7;
	localparam int PB_CAP_BIT     = 6;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [2:0]  CTRL_RST    = 3'h0;
	localparam logic [15:0] COMPARE_RST = 16'hffff;
	localparam logic [15:0] ZERO16      = 16'h0000;
	localparam logic [31:0] BAD_ADDR_RD = 32'h0000_0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TMS_SINGLE   = 2'b00,
		TMS_SIMPLE   = 2'b01,
		TMS_ROM      = 2'b10,
		TMS_ROM_TMR  = 2'b11
	} tms_mode_t;

	typedef struct packed {
		tms_mode_t  mode;
		logic [2:0] scsi_id;
		logic       parity_en;
	} tms_strap_t;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe_n;
	} tms_port_t;

endpackage

/* src/tms_timer.sv */
// Timer, strap latch and port B/C pin sharing
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps

module tms_timer
	import tms_pkg::*;
#(
	parameter logic [1:0] MAP_00 = 2'b00,
	parameter logic [1:0] MAP_01 = 2'b01,
	parameter logic [1:0] MAP_10 = 2'b10,
	parameter logic [1:0] MAP_11 = 2'b11
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Straps
	input  wire logic        mode_strap_one_i,
	input  wire logic        mode_strap_two_i,
	input  wire logic [2:0]  scsi_id_strap_i,
	input  wire logic        parity_strap_i,
	// Port B and C pins
	input  wire logic [7:0]  portb_i,
	output logic      [7:0]  portb_o,
	output logic      [7:0]  portb_oe_n_o,
	input  wire logic [7:0]  portc_i,
	output logic      [7:0]  portc_o,
	output logic      [7:0]  portc_oe_n_o,
	// Expansion bus view of ports
	output logic      [7:0]  exp_b_in_o,
	output logic      [7:0]  exp_c_in_o,
	// Status
	output tms_strap_t       strap_o,
	output logic             irq_o
);

	// ------------------------------------------------------------
	// Wishbone decode
	// ------------------------------------------------------------
	logic        wr;
	logic        rd_ok;
	logic [31:0] rd_data;
	logic        strap_done_reg;
	tms_strap_t  strap_reg;
	logic [15:0] count_reg;
	logic [15:0] compare_reg;
	logic [15:0] capture_reg;
	logic [2:0]  ctrl_reg;
	logic [1:0]  status_reg;
	logic [1:0]  mask_reg;
	logic        cmp_pin_reg;
	logic        cap_prev_reg;
	logic [7:0]  pb_reg;
	logic [7:0]  pc_reg;
	logic [7:0]  ddrb_reg;
	logic [7:0]  ddrc_reg;
	logic [7:0]  expb_reg;
	logic [7:0]  expc_reg;

	assign wr = cyc_i && stb_i && we_i && !ack_o;

	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] s);
		lane0 = s[0] ? d[7:0] : old;
	endfunction

	function automatic logic [15:0] lane01(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		lane01 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
		end
	end

	// ------------------------------------------------------------
	// Strap latch
	// ------------------------------------------------------------
	// Taken on the first edge after release, never from a port under reset
	function automatic tms_mode_t map_mode(input logic [1:0] pins);
		logic [1:0] m;
		m = MAP_00;
		unique case (pins)
			2'b00: m = MAP_00;
			2'b01: m = MAP_01;
			2'b10: m = MAP_10;
			2'b11: m = MAP_11;
		endcase
		map_mode = tms_mode_t'(m);
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_done_reg <= 1'b0;
			strap_reg      <= '{mode: TMS_SINGLE, scsi_id: 3'h0, parity_en: 1'b0};
		end else if (!strap_done_reg) begin
			strap_done_reg     <= 1'b1;
			strap_reg.mode     <= map_mode({mode_strap_two_i, mode_strap_one_i});
			strap_reg.scsi_id  <= scsi_id_strap_i;
			strap_reg.parity_en <= parity_strap_i;
		end
	end

	assign strap_o = strap_reg;

	// ------------------------------------------------------------
	// Pin function select
	// ------------------------------------------------------------
	logic single;
	logic tmr_mode;
	logic tmr_pins;
	logic cap_pin;

	assign single   = (strap_reg.mode == TMS_SINGLE);
	assign tmr_mode = single || (strap_reg.mode == TMS_ROM_TMR);
	assign tmr_pins = tmr_mode && ctrl_reg[CTRL_PIN_EN];
	// Raw pin tracked while disabled, so a steady high never reads as an edge
	assign cap_pin  = portb_i[PB_CAP_BIT];

	// ------------------------------------------------------------
	// Counter, compare, capture
	// ------------------------------------------------------------
	logic cmp_hit;
	logic cap_hit;

	assign cmp_hit = (count_reg == compare_reg);
	// Edge only seen while pin is routed to the timer
	assign cap_hit = tmr_pins && (ctrl_reg[CTRL_CAP_EDGE] ? (cap_pin && !cap_prev_reg)
		: (!cap_pin && cap_prev_reg));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= ZERO16;
		end else begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_prev_reg <= 1'b0;
			capture_reg  <= ZERO16;
		end else begin
			cap_prev_reg <= cap_pin;
			if (cap_hit) begin
				capture_reg <= count_reg;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_pin_reg <= 1'b0;
		end else if (cmp_hit) begin
			cmp_pin_reg <= ctrl_reg[CTRL_CMP_LEVEL];
		end
	end

	// ------------------------------------------------------------
	// Control, compare, mask, port registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg    <= CTRL_RST;
			compare_reg <= COMPARE_RST;
			mask_reg    <= 2'h0;
			pb_reg      <= 8'h00;
			pc_reg      <= 8'h00;
			ddrb_reg    <= 8'h00;
			ddrc_reg    <= 8'h00;
			expb_reg    <= 8'h00;
			expc_reg    <= 8'h00;
		end else if (wr) begin
			unique case (adr_i)
				OFF_CTRL:    ctrl_reg    <= sel_i[0] ? dat_i[2:0] : ctrl_reg;
				OFF_COMPARE: compare_reg <= lane01(compare_reg, dat_i, sel_i);
				OFF_MASK:    mask_reg    <= sel_i[0] ? dat_i[1:0] : mask_reg;
				OFF_PORTB:   pb_reg      <= lane0(pb_reg, dat_i, sel_i);
				OFF_PORTC:   pc_reg      <= lane0(pc_reg, dat_i, sel_i);
				OFF_DDRB:    ddrb_reg    <= lane0(ddrb_reg, dat_i, sel_i);
				OFF_DDRC:    ddrc_reg    <= lane0(ddrc_reg, dat_i, sel_i);
				OFF_EXPB:    expb_reg    <= lane0(expb_reg, dat_i, sel_i);
				OFF_EXPC:    expc_reg    <= lane0(expc_reg, dat_i, sel_i);
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sticky status with write-one-to-clear
	// ------------------------------------------------------------
	logic [1:0] clr;
	logic [1:0] evt;

	assign clr = (wr && adr_i == OFF_STATUS && sel_i[0]) ? dat_i[1:0] : 2'h0;
	assign evt = {cap_hit, cmp_hit};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= 2'h0;
		end else begin
			// Set beats clear in the same cycle
			status_reg <= (status_reg & ~clr) | evt;
		end
	end

	assign irq_o = |(status_reg & mask_reg);

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Expanded modes hand port B to the address/data bus drive; port C drives expc_reg with oe_n taken straight from ddrc_reg
	always_comb begin
		if (single) begin
			portb_o      = pb_reg;
			portb_oe_n_o = ~ddrb_reg;
			portc_o      = pc_reg;
			portc_oe_n_o = ~ddrc_reg;
		end else begin
			portb_o      = expb_reg;
			portb_oe_n_o = 8'h00;
			portc_o      = expc_reg;
			portc_oe_n_o = ddrc_reg;
		end
		if (tmr_pins) begin
			portb_o[PB_CMP_BIT]      = cmp_pin_reg;
			portb_oe_n_o[PB_CMP_BIT] = 1'b0;
			portb_oe_n_o[PB_CAP_BIT] = 1'b1;
		end
	end

	assign exp_b_in_o = portb_i;
	assign exp_c_in_o = portc_i;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = BAD_ADDR_RD;
		unique case (adr_i)
			OFF_CTRL:    rd_data[2:0]  = ctrl_reg;
			OFF_STATUS:  rd_data[1:0]  = status_reg;
			OFF_MASK:    rd_data[1:0]  = mask_reg;
			OFF_COUNT:   rd_data[15:0] = count_reg;
			OFF_COMPARE: rd_data[15:0] = compare_reg;
			OFF_CAPTURE: rd_data[15:0] = capture_reg;
			OFF_STRAP:   rd_data[5:0]  = strap_reg;
			OFF_PORTB:   rd_data[7:0]  = portb_i;
			OFF_PORTC:   rd_data[7:0]  = portc_i;
			OFF_DDRB:    rd_data[7:0]  = ddrb_reg;
			OFF_DDRC:    rd_data[7:0]  = ddrc_reg;
			OFF_EXPB:    rd_data[7:0]  = expb_reg;
			OFF_EXPC:    rd_data[7:0]  = expc_reg;
			default:     rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= BAD_ADDR_RD;
		end else if (cyc_i && stb_i && !we_i && !ack_o) begin
			dat_o <= rd_ok ? rd_data : BAD_ADDR_RD;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_count_wraps: assert property ($past(count_reg) == 16'hffff && !$past(rst_i)
		|-> count_reg == 16'h0000) else $error("counter did not wrap");
	a_count_steps: assert property (!$past(rst_i)
		|-> count_reg == $past(count_reg) + 16'h0001) else $error("counter did not step");
	a_cmp_flag_set: assert property (cmp_hit |=> status_reg[ST_CMP])
		else $error("compare flag missing");
	a_cmp_pin_lvl: assert property (cmp_hit |=> cmp_pin_reg
		== $past(ctrl_reg[CTRL_CMP_LEVEL])) else $error("compare level wrong");
	a_cmp_pin_hold: assert property (!cmp_hit |=> $stable(cmp_pin_reg))
		else $error("compare pin moved without match");
	a_cap_latch: assert property (cap_hit |=> capture_reg == $past(count_reg)
		&& status_reg[ST_CAP]) else $error("capture not latched");
	a_cap_hold: assert property (!cap_hit |=> $stable(capture_reg))
		else $error("capture moved without edge");

	// ------------------------------------------------------------
	// Pin, strap and flag assertions
	// ------------------------------------------------------------
	a_pins_mode: assert property (strap_reg.mode inside {TMS_SIMPLE, TMS_ROM}
		|-> !cap_hit && portb_o == expb_reg) else $error("timer pins in wrong mode");
	a_strap_hold: assert property (strap_done_reg && $past(strap_done_reg)
		|-> $stable(strap_reg)) else $error("strap changed");
	a_strap_taken: assert property (!rst_i && !strap_done_reg |=> strap_done_reg
		&& strap_reg.scsi_id == $past(scsi_id_strap_i)
		&& strap_reg.parity_en == $past(parity_strap_i)) else $error("strap not taken");
	a_cmp_drive: assert property (tmr_pins |-> !portb_oe_n_o[PB_CMP_BIT]
		&& portb_o[PB_CMP_BIT] == cmp_pin_reg) else $error("compare pin not driven");
	a_cap_input: assert property (tmr_pins |-> portb_oe_n_o[PB_CAP_BIT])
		else $error("capture pin driven");
	a_exp_drive: assert property (!single && !tmr_pins |-> portb_oe_n_o == 8'h00)
		else $error("expansion port not driven");
	a_single_ports: assert property (single && !tmr_pins |-> portb_o == pb_reg
		&& portb_oe_n_o == ~ddrb_reg && portc_o == pc_reg) else $error("parallel port wrong");
	a_flag_sticky: assert property (status_reg[ST_CMP] && clr == 2'h0
		|=> status_reg[ST_CMP]) else $error("flag dropped");
	a_cap_sticky: assert property (status_reg[ST_CAP] && !clr[ST_CAP]
		|=> status_reg[ST_CAP]) else $error("capture flag dropped");
	a_flag_w1c: assert property (clr[ST_CAP] && !cap_hit |=> !status_reg[ST_CAP])
		else $error("capture flag not cleared");

	// ------------------------------------------------------------
	// Covers
	// ------------------------------------------------------------
	c_compare: cover property (cmp_hit ##1 irq_o);
	c_capture: cover property (cap_hit);
	c_clear: cover property (status_reg[ST_CAP] ##1 !status_reg[ST_CAP]);
	c_rom_tmr: cover property (strap_reg.mode == TMS_ROM_TMR && tmr_pins);
	c_falling: cover property (cap_hit && !ctrl_reg[CTRL_CAP_EDGE]);

endmodule

/* verif/tms_pins_model.sv */
// External pin model: strap resistors, capture source, port pin levels
`timescale 1ns/1ps

module tms_pins_model
	import tms_pkg::*;
(
	// Controls
	input  wire logic       clk_i,
	input  wire logic [1:0] sel_i,
	input  wire logic       cap_i,
	// Design pin drivers
	input  wire tms_port_t  pb_i,
	input  wire tms_port_t  pc_i,
	// Pin levels
	output logic      [1:0] strap_o,
	output logic      [7:0] pb_o,
	output logic      [7:0] pc_o
);
	logic [7:0] flt;

	// ----
	// Straps
	// ----
	// Resistor straps stay put, so the reset sample never races
	assign strap_o = sel_i;

	// ----
	// Wire levels
	// ----
	// Released port B lines other than bit 6 toggle so a stale level never reads as valid; released port C lines sit at 3c
	initial flt = 8'h55;
	always @(posedge clk_i) begin
		flt <= ~flt;
	end
	// Design wins where it drives; capture source sits on bit 6
	always_comb begin
		pb_o = (~pb_i.oe_n & pb_i.o) | (pb_i.oe_n & {flt[7], cap_i, flt[5:0]});
		pc_o = (~pc_i.oe_n & pc_i.o) | (pc_i.oe_n & 8'h3c);
	end
endmodule

/* verif/tb_tms_timer.sv */
// Self-checking bench for the timer with mode strap block
`timescale 1ns/1ps

module tb_tms_timer
	import tms_pkg::*;
();
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        irq_o;
	logic        cap;
	logic [1:0]  ssel;
	logic [1:0]  spin;
	logic [7:0]  pbi, pci, pbo, pbn, pco, pcn, ebi, eci;
	tms_strap_t  strap_o;
	logic [31:0] q, c0, c1;
	logic [15:0] d16;
	int          fail_count;
	int          samples_checked;
	int          cycles;

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	tms_timer i_tms_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .mode_strap_one_i(spin[0]), .mode_strap_two_i(spin[1]),
		.scsi_id_strap_i(3'h5), .parity_strap_i(1'b1), .portb_i(pbi), .portb_o(pbo),
		.portb_oe_n_o(pbn), .portc_i(pci), .portc_o(pco), .portc_oe_n_o(pcn),
		.exp_b_in_o(ebi), .exp_c_in_o(eci), .strap_o(strap_o), .irq_o(irq_o));

	tms_pins_model i_tms_pins_model (.clk_i(clk_i), .sel_i(ssel), .cap_i(cap),
		.pb_i({pbo, pbn}), .pc_i({pco, pcn}), .strap_o(spin), .pb_o(pbi), .pc_o(pci));

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Classic cycle; the slave sets the pace, a 20-cycle bound ends a wait with no ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			fail_count++;
			final_report();
		end
	endtask

	task automatic do_reset(input logic [1:0] m);
		@(posedge clk_i);
		ssel <= m;
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// Falling edge must not capture; rising edge must, when usable
	task automatic cap_try(input logic [31:0] exp_flag);
		cap <= 1'b1;
		bus(1'b1, OFF_STATUS, 32'h3);
		cap <= 1'b0;
		bus(1'b0, OFF_COUNT, 32'h0);
		c0 = q;
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(q & 32'h2, 32'h0);
		cap <= 1'b1;
		bus(1'b0, OFF_COUNT, 32'h0);
		c1 = q;
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(q & 32'h2, exp_flag);
		bus(1'b0, OFF_CAPTURE, 32'h0);
		if (exp_flag != 0) begin
			chk(32'(q[15:0] > c0[15:0] && q[15:0] < c1[15:0]), 32'h1);
		end
	endtask

	// Hang guard: the wrap wait dominates the run
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			fail_count++;
			final_report();
		end
	end

	// ----
	// Sequence
	// ----
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		dat_i = 32'h0;
		cap = 1'b0;
		ssel = 2'b00;
		fail_count = 0;
		samples_checked = 0;
		cycles = 0;
		do_reset(2'b00);
		chk(32'(strap_o), {26'h0, TMS_SINGLE, 3'h5, 1'b1});
		bus(1'b0, OFF_COUNT, 32'h0);
		c0 = q;
		bus(1'b1, OFF_COUNT, 32'h0);
		repeat (65536) @(posedge clk_i);
		bus(1'b0, OFF_COUNT, 32'h0);
		d16 = q[15:0] - c0[15:0];
		chk({q[31:16], d16}, 32'h6);
		bus(1'b1, OFF_STATUS, 32'h3);
		bus(1'b1, OFF_MASK, 32'h1);
		for (int lv = 1; lv >= 0; lv--) begin
			bus(1'b1, OFF_CTRL, lv ? 32'h7 : 32'h5);
			bus(1'b0, OFF_COUNT, 32'h0);
			bus(1'b1, OFF_COMPARE, q + 32'h14);
			repeat (30) @(posedge clk_i);
			chk(32'({pbn[PB_CMP_BIT], pbo[PB_CMP_BIT]}), 32'(lv));
			chk(32'(irq_o), 32'h1);
			bus(1'b1, OFF_MASK, 32'h0);
			chk(32'(irq_o), 32'h0);
			bus(1'b1, OFF_MASK, 32'h1);
			bus(1'b0, OFF_STATUS, 32'h0);
			chk(q, 32'h1);
			bus(1'b1, OFF_STATUS, 32'h1);
			bus(1'b0, OFF_STATUS, 32'h0);
			chk({q[30:0], irq_o}, 32'h0);
		end
		bus(1'b1, OFF_DDRC, 32'h0f);
		bus(1'b1, OFF_PORTC, 32'ha5);
		chk(32'({pcn, pco[3:0]}), 32'hf05);
		bus(1'b0, OFF_PORTC, 32'h0);
		chk(q, 32'h35);
		cap_try(32'h2);
		do_reset(2'b10);
		chk(32'(strap_o.mode), 32'(TMS_ROM));
		do_reset(2'b01);
		chk(32'(strap_o.mode), 32'(TMS_SIMPLE));
		bus(1'b1, OFF_CTRL, 32'h5);
		bus(1'b1, OFF_EXPB, 32'h5a);
		chk(32'({pbn, pbo}), 32'h005a);
		chk(32'({ebi, eci}), 32'h5a00);
		cap_try(32'h0);
		do_reset(2'b11);
		chk(32'(strap_o.mode), 32'(TMS_ROM_TMR));
		bus(1'b1, OFF_CTRL, 32'h5);
		chk(32'(pbn[PB_CAP_BIT]), 32'h1);
		cap_try(32'h2);
		bus(1'b1, OFF_CTRL, 32'h1);
		bus(1'b1, OFF_STATUS, 32'h3);
		bus(1'b0, OFF_COUNT, 32'h0);
		c0 = q;
		cap <= 1'b0;
		bus(1'b0, OFF_COUNT, 32'h0);
		c1 = q;
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(q & 32'h2, 32'h2);
		bus(1'b0, OFF_CAPTURE, 32'h0);
		chk(32'(q[15:0] > c0[15:0] && q[15:0] < c1[15:0]), 32'h1);
		final_report();
	end
endmodule
